/* File: dhce_defs.vh */
// constants shared by the hash and cipher engine
`ifndef DHCE_DEFS_VH
`define DHCE_DEFS_VH
`define DHCE_ADDR_W        35
`define DHCE_CMD_MOVE      4'h1
`define DHCE_CMD_ZERO      4'h2
`define DHCE_CMD_DG_ONE    4'h3
`define DHCE_CMD_DG_BEGIN  4'h4
`define DHCE_CMD_DG_PIECE  4'h5
`define DHCE_CMD_DG_END    4'h6
`define DHCE_CMD_KEY_EXP   4'h7
`define DHCE_ST_OK         1'b0
`define DHCE_ST_BUSY       1'b1
`define DHCE_AES_LAST_RND  4'he
`define DHCE_AES_LAST_KW   6'h3b
`define DHCE_DG_BLK_BYTES  7'h40
`define DHCE_DG_LEN_POS    7'h38
`define DHCE_DG_IV { \
  32'h6a09_e667, 32'hbb67_ae85, 32'h3c6e_f372, 32'ha54f_f53a, \
  32'h510e_527f, 32'h9b05_688c, 32'h1f83_d9ab, 32'h5be0_cd19}
`define DHCE_DG_K { \
  32'h428a_2f98, 32'h7137_4491, 32'hb5c0_fbcf, 32'he9b5_dba5, \
  32'h3956_c25b, 32'h59f1_11f1, 32'h923f_82a4, 32'hab1c_5ed5, \
  32'hd807_aa98, 32'h1283_5b01, 32'h2431_85be, 32'h550c_7dc3, \
  32'h72be_5d74, 32'h80de_b1fe, 32'h9bdc_06a7, 32'hc19b_f174, \
  32'he49b_69c1, 32'hefbe_4786, 32'h0fc1_9dc6, 32'h240c_a1cc, \
  32'h2de9_2c6f, 32'h4a74_84aa, 32'h5cb0_a9dc, 32'h76f9_88da, \
  32'h983e_5152, 32'ha831_c66d, 32'hb003_27c8, 32'hbf59_7fc7, \
  32'hc6e0_0bf3, 32'hd5a7_9147, 32'h06ca_6351, 32'h1429_2967, \
  32'h27b7_0a85, 32'h2e1b_2138, 32'h4d2c_6dfc, 32'h5338_0d13, \
  32'h650a_7354, 32'h766a_0abb, 32'h81c2_c92e, 32'h9272_2c85, \
  32'ha2bf_e8a1, 32'ha81a_664b, 32'hc24b_8b70, 32'hc76c_51a3, \
  32'hd192_e819, 32'hd699_0624, 32'hf40e_3585, 32'h106a_a070, \
  32'h19a4_c116, 32'h1e37_6c08, 32'h2748_774c, 32'h34b0_bcb5, \
  32'h391c_0cb3, 32'h4ed8_aa4a, 32'h5b9c_ca4f, 32'h682e_6ff3, \
  32'h748f_82ee, 32'h78a5_636f, 32'h84c8_7814, 32'h8cc7_0208, \
  32'h90be_fffa, 32'ha450_6ceb, 32'hbef9_a3f7, 32'hc671_78f2}
`endif

/* File: dhce_aes_core.v */
// block cipher core: key schedule store, one round per clock
`timescale 1ns/1ns
`include "dhce_defs.vh"
module dhce_aes_core (
  input  wire         i_clk,   // system clock
  input  wire         i_rst_b, // synchronised reset, active low
  input  wire [255:0] i_key,   // raw key, word 0 in the top bits
  input  wire         i_kx_go, // pulse: build round keys
  input  wire         i_go,    // pulse: run one block
  input  wire         i_dec,   // 1 selects the decipher path
  input  wire [127:0] i_blk,   // block in
  output reg          o_done,  // pulse: key build or block finished
  output reg  [127:0] o_blk    // working state, result when done
);
  reg [31:0]  w [0:59];
  reg [5:0]   ki;
  reg [7:0]   rcon;
  reg [3:0]   rnd;
  reg         kx;
  reg         run;
  reg         dec;
  reg [127:0] sr, sb, ak, mx, rk, nxt;
  reg [31:0]  kt;
  reg [7:0]   b0, b1, b2, b3;
  integer     n, r, c, j;
  wire [3:0]  last = dec ? 4'h0 : `DHCE_AES_LAST_RND;

  function [7:0] xt;
    input [7:0] a;
    begin
      xt = {a[6:0], 1'b0} ^ (a[7] ? 8'h1b : 8'h00);
    end
  endfunction

  function [7:0] gm;
    input [7:0] a;
    input [7:0] b;
    integer k;
    reg [7:0] p, x;
    begin
      p = 8'h00;
      x = a;
      for (k = 0; k < 8; k = k + 1) begin
        if (b[k]) p = p ^ x;
        x = xt(x);
      end
      gm = p;
    end
  endfunction

  // field inverse as a to the power 254
  function [7:0] inv;
    input [7:0] a;
    reg [7:0] a2, a3, a12, a15, a240;
    begin
      a2   = gm(a, a);
      a3   = gm(a2, a);
      a12  = gm(gm(a3, a3), gm(a3, a3));
      a15  = gm(a12, a3);
      a240 = gm(a15, a15);
      a240 = gm(a240, a240);
      a240 = gm(a240, a240);
      a240 = gm(a240, a240);
      inv  = gm(gm(a240, a12), a2);
    end
  endfunction

  function [7:0] sbx;
    input [7:0] a;
    reg [7:0] b;
    begin
      b   = inv(a);
      sbx = b ^ {b[6:0], b[7]} ^ {b[5:0], b[7:6]} ^ {b[4:0], b[7:5]}
            ^ {b[3:0], b[7:4]} ^ 8'h63;
    end
  endfunction

  function [7:0] isbx;
    input [7:0] a;
    begin
      isbx = inv({a[6:0], a[7]} ^ {a[4:0], a[7:5]} ^ {a[1:0], a[7:2]}
                 ^ 8'h05);
    end
  endfunction

  always @* begin
    rk = {w[{rnd, 2'h0}], w[{rnd, 2'h1}], w[{rnd, 2'h2}], w[{rnd, 2'h3}]};
    sr = 128'h0;
    sb = 128'h0;
    mx = 128'h0;
    for (n = 0; n < 16; n = n + 1) begin
      r = n % 4;
      c = n / 4;
      if (dec)
        sr[127-8*n -: 8] = o_blk[127-8*(r+4*((c+4-r)%4)) -: 8];
      else
        sr[127-8*n -: 8] = o_blk[127-8*(r+4*((c+r)%4)) -: 8];
      sb[127-8*n -: 8] = dec ? isbx(sr[127-8*n -: 8])
                             : sbx(sr[127-8*n -: 8]);
    end
    ak = sb ^ rk;
    for (n = 0; n < 16; n = n + 1) begin
      r  = n % 4;
      c  = 4 * (n / 4);
      b0 = dec ? ak[127-8*(c+r) -: 8]       : sb[127-8*(c+r) -: 8];
      b1 = dec ? ak[127-8*(c+(r+1)%4) -: 8] : sb[127-8*(c+(r+1)%4) -: 8];
      b2 = dec ? ak[127-8*(c+(r+2)%4) -: 8] : sb[127-8*(c+(r+2)%4) -: 8];
      b3 = dec ? ak[127-8*(c+(r+3)%4) -: 8] : sb[127-8*(c+(r+3)%4) -: 8];
      mx[127-8*n -: 8] = dec ?
        gm(b0, 8'h0e) ^ gm(b1, 8'h0b) ^ gm(b2, 8'h0d) ^ gm(b3, 8'h09) :
        gm(b0, 8'h02) ^ gm(b1, 8'h03) ^ b2 ^ b3;
    end
    // separate paths for the two directions on one schedule
    nxt = (rnd == last) ? ak : (dec ? mx : mx ^ rk);
    kt  = w[ki - 6'h01];
    if (ki[2:0] == 3'h0) begin
      kt = {kt[23:0], kt[31:24]};
      kt = {sbx(kt[31:24]), sbx(kt[23:16]), sbx(kt[15:8]), sbx(kt[7:0])}
           ^ {rcon, 24'h00_0000};
    end else if (ki[2:0] == 3'h4) begin
      kt = {sbx(kt[31:24]), sbx(kt[23:16]), sbx(kt[15:8]), sbx(kt[7:0])};
    end
  end

  // schedule storage holds until the next key build
  always @(posedge i_clk) begin
    if (i_kx_go) begin
      for (j = 0; j < 8; j = j + 1)
        w[j] <= i_key[255-32*j -: 32];
    end else if (kx) begin
      w[ki] <= w[ki - 6'h08] ^ kt; // 60 words, 15 round keys
    end
  end

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_done <= 1'b0;
      o_blk  <= 128'h0;
      ki     <= 6'h00;
      rcon   <= 8'h00;
      rnd    <= 4'h0;
      kx     <= 1'b0;
      run    <= 1'b0;
      dec    <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_kx_go) begin
        ki   <= 6'h08;
        rcon <= 8'h01;
        kx   <= 1'b1;
      end else if (kx) begin
        if (ki[2:0] == 3'h0) rcon <= xt(rcon);
        if (ki == `DHCE_AES_LAST_KW) begin
          kx     <= 1'b0;
          o_done <= 1'b1;
        end else begin
          ki <= ki + 6'h01;
        end
      end
      if (i_go) begin
        dec   <= i_dec;
        o_blk <= i_blk ^ (i_dec ? {w[56], w[57], w[58], w[59]}
                                : {w[0], w[1], w[2], w[3]});
        rnd   <= i_dec ? 4'hd : 4'h1;
        run   <= 1'b1;
      end else if (run) begin
        o_blk <= nxt;
        if (rnd == last) begin
          run    <= 1'b0;
          o_done <= 1'b1;
        end else begin
          rnd <= dec ? rnd - 4'h1 : rnd + 4'h1;
        end
      end
    end
  end
endmodule

/* File: dhce_engine.v */
// memory-to-memory engine: move, zero-fill, digest, block cipher
`timescale 1ns/1ns
`include "dhce_defs.vh"
module dhce_engine #(
  parameter AW = `DHCE_ADDR_W // physical address and length width
) (
  input  wire          i_clk_sys,         // system clock
  input  wire          i_rst_b,           // async reset, active low
  input  wire          i_op_wr,           // pulse: command written
  input  wire [3:0]    i_op_code,         // command code
  input  wire [AW-1:0] i_src_ptr,         // source pointer
  input  wire [AW-1:0] i_dst_ptr,         // destination pointer
  input  wire [AW-1:0] i_transfer_length, // length in bytes
  input  wire [63:0]   i_key_word_0,      // key, top doubleword
  input  wire [63:0]   i_key_word_1,      // key doubleword 1
  input  wire [63:0]   i_key_word_2,      // key doubleword 2
  input  wire [63:0]   i_key_word_3,      // key, bottom doubleword
  output reg           o_task_state,      // 0 done, 1 busy
  output reg           o_done,            // pulse: task complete
  output wire [63:0]   o_digest_word_0,   // digest top 64 bits
  output wire [63:0]   o_digest_word_1,   // digest bits 191..128
  output wire [63:0]   o_digest_word_2,   // digest bits 127..64
  output wire [63:0]   o_digest_word_3,   // digest low 64 bits
  output reg           o_mem_req,         // memory access request
  output reg           o_mem_we,          // 1 write, 0 read
  output reg  [AW-1:0] o_mem_addr,        // byte address, doubleword aligned
  output reg  [63:0]   o_mem_wdata,       // write data
  input  wire          i_mem_ack,         // pulse: access done
  input  wire [63:0]   i_mem_rdata        // read data, valid with ack
);
  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_NEXT = 4'h1;
  localparam [3:0] S_RD   = 4'h2;
  localparam [3:0] S_FEED = 4'h3;
  localparam [3:0] S_COMP = 4'h4;
  localparam [3:0] S_SADD = 4'h5;
  localparam [3:0] S_AES  = 4'h6;
  localparam [3:0] S_WR   = 4'h7;
  localparam [3:0] S_KEYX = 4'h8;
  localparam [3:0] S_DONE = 4'h9;
  localparam [AW-1:0]  STEP   = 8;
  localparam [AW-1:0]  ONE    = 1;
  localparam [255:0]   DG_IV  = `DHCE_DG_IV;
  localparam [2047:0]  DG_K   = `DHCE_DG_K;

  reg          rst_s1, rst_s2;
  reg [3:0]    st;
  reg [3:0]    op;
  reg [AW-1:0] src, dst, rem;
  reg [63:0]   dw;
  reg [3:0]    fb;
  reg          pad, ph, fin, half, aes_dec, aes_go, kx_go;
  reg [6:0]    cnt;
  reg [63:0]   tot;
  reg [511:0]  blk;
  reg [255:0]  hv, wv;
  reg [5:0]    rnd;
  reg [127:0]  rbuf, wbuf, iv;
  wire         rst_n = rst_s2;
  wire         aes_done;
  wire [127:0] aes_out;
  wire [255:0] hsum;

  function [31:0] ror;
    input [31:0] x;
    input [4:0]  n;
    begin
      ror = (x >> n) | (x << (6'd32 - {1'b0, n}));
    end
  endfunction

  // digest round datapath
  wire [31:0] ra = wv[255:224];
  wire [31:0] rb = wv[223:192];
  wire [31:0] rc = wv[191:160];
  wire [31:0] rd = wv[159:128];
  wire [31:0] re = wv[127:96];
  wire [31:0] rf = wv[95:64];
  wire [31:0] rg = wv[63:32];
  wire [31:0] rh = wv[31:0];
  wire [31:0] w0 = blk[511:480];
  wire [31:0] w1 = blk[479:448];
  wire [31:0] w9 = blk[223:192];
  wire [31:0] w14 = blk[63:32];
  wire [31:0] kt = DG_K[{(6'd63 - rnd), 5'h00} +: 32];
  wire [31:0] t1 = rh + (ror(re, 5'd6) ^ ror(re, 5'd11) ^ ror(re, 5'd25))
                  + ((re & rf) ^ (~re & rg)) + kt + w0;
  wire [31:0] t2 = (ror(ra, 5'd2) ^ ror(ra, 5'd13) ^ ror(ra, 5'd22))
                  + ((ra & rb) ^ (ra & rc) ^ (rb & rc));
  wire [31:0] wnew = (ror(w14, 5'd17) ^ ror(w14, 5'd19) ^ (w14 >> 10))
                    + w9 + (ror(w1, 5'd7) ^ ror(w1, 5'd18) ^ (w1 >> 3))
                    + w0;
  wire        dg_op = (op == `DHCE_CMD_DG_ONE) || (op == `DHCE_CMD_DG_PIECE);
  wire [3:0]  take = (rem > STEP) ? 4'h8 : rem[3:0];
  // chaining: enciphered input mixes the previous block first
  wire [127:0] aes_in = aes_dec ? rbuf : rbuf ^ iv;

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_hadd
      assign hsum[32*g +: 32] = hv[32*g +: 32] + wv[32*g +: 32];
    end
  endgenerate

  // digest words big-endian, most significant first
  assign o_digest_word_0 = hv[255:192];
  assign o_digest_word_1 = hv[191:128];
  assign o_digest_word_2 = hv[127:64];
  assign o_digest_word_3 = hv[63:0];

  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  dhce_aes_core u_aes (
    .i_clk   (i_clk_sys),
    .i_rst_b (rst_n),
    .i_key   ({i_key_word_0, i_key_word_1, i_key_word_2, i_key_word_3}),
    .i_kx_go (kx_go),
    .i_go    (aes_go),
    .i_dec   (aes_dec),
    .i_blk   (aes_in),
    .o_done  (aes_done),
    .o_blk   (aes_out)
  );

  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= S_IDLE;
      op <= 4'h0;
      src <= {AW{1'b0}};
      dst <= {AW{1'b0}};
      rem <= {AW{1'b0}};
      dw <= 64'h0;
      fb <= 4'h0;
      pad <= 1'b0;
      ph <= 1'b0;
      fin <= 1'b0;
      half <= 1'b0;
      aes_dec <= 1'b0;
      aes_go <= 1'b0;
      kx_go <= 1'b0;
      cnt <= 7'h00;
      tot <= 64'h0;
      blk <= 512'h0;
      hv <= DG_IV;
      wv <= 256'h0;
      rnd <= 6'h00;
      rbuf <= 128'h0;
      wbuf <= 128'h0;
      iv <= 128'h0;
      o_task_state <= `DHCE_ST_OK;
      o_done <= 1'b0;
      o_mem_req <= 1'b0;
      o_mem_we <= 1'b0;
      o_mem_addr <= {AW{1'b0}};
      o_mem_wdata <= 64'h0;
    end else begin
      o_done <= 1'b0;
      aes_go <= 1'b0;
      kx_go <= 1'b0;
      case (st)
        S_IDLE: if (i_op_wr) begin // arguments latched at command
          o_task_state <= `DHCE_ST_BUSY;
          op <= i_op_code;
          fin <= 1'b0;
          pad <= 1'b0;
          ph <= 1'b0;
          fb <= 4'h0;
          half <= 1'b0;
          // physical pointers, low bits dropped
          src <= {i_src_ptr[AW-1:3], 3'h0};
          if (i_op_code == `DHCE_CMD_ZERO)
            dst <= {i_src_ptr[AW-1:3], 3'h0};
          else
            dst <= {i_dst_ptr[AW-1:3], 3'h0};
          case (i_op_code)
            `DHCE_CMD_MOVE, `DHCE_CMD_ZERO: begin
              rem <= {3'h0, i_transfer_length[AW-1:3]};
              st <= S_NEXT;
            end
            `DHCE_CMD_DG_ONE: begin // begin, piece and end in one
              hv <= DG_IV;
              cnt <= 7'h00;
              tot <= 64'h0;
              rem <= i_transfer_length;
              fin <= 1'b1;
              st <= S_FEED;
            end
            `DHCE_CMD_DG_BEGIN: begin
              hv <= DG_IV;
              cnt <= 7'h00;
              tot <= 64'h0;
              st <= S_DONE;
            end
            `DHCE_CMD_DG_PIECE: begin // running state kept
              rem <= i_transfer_length;
              st <= S_FEED;
            end
            `DHCE_CMD_DG_END: begin
              dw <= {8'h80, 56'h0};
              fb <= 4'h1;
              pad <= 1'b1;
              st <= S_FEED;
            end
            `DHCE_CMD_KEY_EXP: begin
              kx_go <= 1'b1;
              st <= S_KEYX;
            end
            default: if (i_op_code[3]) begin
              // whole 16-byte blocks only
              rem <= {4'h0, i_transfer_length[AW-1:4]};
              aes_dec <= i_op_code[2];
              if (i_op_code[1:0] <= 2'h1)
                iv <= 128'h0; // single and first restart chain
              st <= S_NEXT;
            end else begin
              st <= S_DONE;
            end
          endcase
        end
        S_NEXT: begin
          if (rem == {AW{1'b0}})
            st <= S_DONE;
          else if (op == `DHCE_CMD_ZERO) begin
            wbuf <= 128'h0;
            st <= S_WR;
          end else
            st <= S_RD;
        end
        S_RD: if (i_mem_ack) begin
          o_mem_req <= 1'b0;
          src <= src + STEP;
          rbuf <= {rbuf[63:0], i_mem_rdata};
          if (op == `DHCE_CMD_MOVE) begin
            wbuf <= {i_mem_rdata, 64'h0};
            st <= S_WR;
          end else if (dg_op) begin
            dw <= i_mem_rdata; // tail doubleword may be partial
            fb <= take;
            rem <= rem - {{(AW-4){1'b0}}, take};
            st <= S_FEED;
          end else if (!half) begin
            half <= 1'b1;
          end else begin
            half <= 1'b0;
            aes_go <= 1'b1;
            st <= S_AES;
          end
        end else begin
          o_mem_req <= 1'b1;
          o_mem_we <= 1'b0;
          o_mem_addr <= src;
        end
        S_AES: if (aes_done) begin
          wbuf <= aes_dec ? aes_out ^ iv : aes_out;
          iv <= aes_dec ? rbuf : aes_out; // chain carried on
          st <= S_WR;
        end
        S_WR: if (i_mem_ack) begin
          o_mem_req <= 1'b0;
          o_mem_we <= 1'b0;
          dst <= dst + STEP;
          if (op[3] && !half) begin
            half <= 1'b1;
            wbuf <= {wbuf[63:0], 64'h0};
          end else begin
            half <= 1'b0;
            rem <= rem - ONE;
            st <= S_NEXT;
          end
        end else begin
          o_mem_req <= 1'b1;
          o_mem_we <= 1'b1;
          o_mem_addr <= dst;
          o_mem_wdata <= wbuf[127:64];
        end
        S_FEED: begin
          if (cnt == `DHCE_DG_BLK_BYTES) begin
            wv <= hv;
            rnd <= 6'h00;
            st <= S_COMP;
          end else if (fb != 4'h0) begin
            // bytes shift in one by one across pieces
            blk <= {blk[503:0], dw[63:56]};
            dw <= {dw[55:0], 8'h00};
            fb <= fb - 4'h1;
            cnt <= cnt + 7'h01;
            if (!pad)
              tot <= tot + 64'h8;
          end else if (pad) begin
            if (ph)
              st <= S_DONE;
            else if (cnt == `DHCE_DG_LEN_POS) begin
              dw <= tot;
              fb <= 4'h8;
              ph <= 1'b1;
            end else begin
              dw <= 64'h0;
              fb <= 4'h1;
            end
          end else if (rem != {AW{1'b0}}) begin
            st <= S_RD;
          end else if (fin) begin
            dw <= {8'h80, 56'h0};
            fb <= 4'h1;
            pad <= 1'b1;
          end else begin
            st <= S_DONE;
          end
        end
        S_COMP: begin
          wv <= {t1 + t2, ra, rb, rc, rd + t1, re, rf, rg};
          blk <= {blk[479:0], wnew};
          rnd <= rnd + 6'h01;
          if (rnd == 6'h3f)
            st <= S_SADD;
        end
        S_SADD: begin
          hv <= hsum;
          cnt <= 7'h00;
          st <= S_FEED;
        end
        S_KEYX: if (aes_done)
          st <= S_DONE;
        S_DONE: begin // reached when the command's work ends; begin and unknown codes come straight here
          o_task_state <= `DHCE_ST_OK;
          o_done <= 1'b1;
          st <= S_IDLE;
        end
        default: st <= S_IDLE;
      endcase
    end
  end
endmodule

/* File: dhce_engine_chk.sv */
// port checker for the hash and cipher engine
`timescale 1ns/1ns
module dhce_engine_chk #(
  parameter AW = 35
) (
  input wire          i_clk_sys,   // system clock
  input wire          i_rst_b,     // reset, active low
  input wire          i_op_wr,     // command strobe
  input wire [3:0]    i_op_code,   // command code
  input wire          o_task_state,// busy level
  input wire          o_done,      // completion pulse
  input wire          o_mem_req,   // memory request
  input wire          o_mem_we,    // memory write
  input wire [AW-1:0] o_mem_addr,  // memory address
  input wire [63:0]   o_mem_wdata, // memory write data
  input wire          i_mem_ack    // memory ack
);
  reg [3:0] cur;
  wire      take = i_op_wr && !o_task_state;
  // command now running
  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b)
      cur <= 4'h0;
    else if (take)
      cur <= i_op_code;
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  a_done_idle: assert property (o_done |-> !o_task_state)
    else $error("done pulse while busy");
  a_done_pulse: assert property (o_done |=> !o_done)
    else $error("done longer than one cycle");
  a_take_busy: assert property (take |=> o_task_state)
    else $error("command not taken");
  a_done_had: assert property (o_done |-> $past(o_task_state))
    else $error("done without a task");
  a_idle_no_req: assert property (!o_task_state |-> !o_mem_req)
    else $error("memory request while idle");
  a_req_hold: assert property (o_mem_req && !i_mem_ack |=>
    o_mem_req && $stable(o_mem_addr) && $stable(o_mem_wdata))
    else $error("request changed before ack");
  a_zero_data: assert property (o_mem_req && cur == 4'h2 |->
    o_mem_we && o_mem_wdata == 64'h0 && o_mem_addr[2:0] == 3'h0)
    else $error("zero fill wrote bad data");
  a_digest_read: assert property (o_mem_req && cur >= 4'h3 &&
    cur <= 4'h6 |-> !o_mem_we)
    else $error("digest wrote memory");
  a_begin_quick: assert property (take && i_op_code == 4'h4 |->
    ##2 o_done)
    else $error("digest begin not done in two cycles");
  a_key_bound: assert property (take && i_op_code == 4'h7 |->
    ##[2:120] o_done)
    else $error("key expand too slow");
endmodule

/* File: dhce_mem_model.sv */
// doubleword memory answering the engine, promptly or with waits
`timescale 1ns/1ns
module dhce_mem_model (
  input  wire        i_clk,   // system clock
  input  wire        i_slow,  // 1 adds wait cycles
  input  wire        i_req,   // request
  input  wire        i_we,    // 1 write
  input  wire [34:0] i_addr,  // byte address
  input  wire [63:0] i_wdata, // write data
  output reg         o_ack,   // one-cycle ack
  output reg  [63:0] o_rdata  // read data with ack
);
  reg [63:0] m [0:255];
  reg [1:0]  wait_cnt = 2'h0;
  initial o_ack = 1'b0;
  initial o_rdata = 64'h0;
  always @(posedge i_clk) begin
    o_ack <= 1'b0;
    o_rdata <= ~o_rdata; // no stale data outside ack
    if (i_req && !o_ack) begin
      if (!i_slow || wait_cnt == 2'h3) begin
        o_ack <= 1'b1;
        wait_cnt <= 2'h0;
        if (i_we)
          m[i_addr[10:3]] <= i_wdata;
        else
          o_rdata <= m[i_addr[10:3]];
      end else
        wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule

/* File: tb_top.sv */
// testbench for the hash and cipher engine
`timescale 1ns/1ns
module tb_top;
  localparam [255:0] ABC = {64'hba78_16bf_8f01_cfea,
    64'h4141_40de_5dae_2223, 64'hb003_61a3_9617_7a9c,
    64'hb410_ff61_f200_15ad};
  localparam [63:0] PH = 64'h0011_2233_4455_6677;
  localparam [63:0] PL = 64'h8899_aabb_ccdd_eeff;
  localparam [63:0] CH = 64'h8ea2_b7ca_5167_45bf;
  localparam [63:0] CL = 64'heafc_4990_4b49_6089;
  reg         clk = 1'b0;
  reg         rst_b = 1'b0;
  reg         op_wr = 1'b0;
  reg         slow = 1'b0;
  reg  [3:0]  code = 4'h0;
  reg  [34:0] src = 35'h0;
  reg  [34:0] dst = 35'h0;
  reg  [34:0] len = 35'h0;
  reg  [255:0] key = {64'h0001_0203_0405_0607, 64'h0809_0a0b_0c0d_0e0f,
    64'h1011_1213_1415_1617, 64'h1819_1a1b_1c1d_1e1f};
  wire        busy, done, req, we, ack;
  wire [34:0] addr;
  wire [63:0] wdata, rdata, d0, d1, d2, d3;
  integer     n_mismatch = 0;
  integer     checks_done = 0;
  integer     cyc = 0;
  integer     i;
  always #20 clk = ~clk;
  dhce_engine dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_op_wr(op_wr),
    .i_op_code(code), .i_src_ptr(src), .i_dst_ptr(dst),
    .i_transfer_length(len), .i_key_word_0(key[255:192]),
    .i_key_word_1(key[191:128]), .i_key_word_2(key[127:64]),
    .i_key_word_3(key[63:0]), .o_task_state(busy),
    .o_done(done), .o_digest_word_0(d0), .o_digest_word_1(d1),
    .o_digest_word_2(d2), .o_digest_word_3(d3), .o_mem_req(req),
    .o_mem_we(we), .o_mem_addr(addr), .o_mem_wdata(wdata),
    .i_mem_ack(ack), .i_mem_rdata(rdata));
  dhce_mem_model mem (.i_clk(clk), .i_slow(slow), .i_req(req),
    .i_we(we), .i_addr(addr), .i_wdata(wdata), .o_ack(ack),
    .o_rdata(rdata));
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input [63:0] g, input [63:0] e);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
    end
  endtask
  task run(input [3:0] c, input [34:0] s, input [34:0] d,
           input [34:0] l);
    integer k;
    begin
      @(posedge clk);
      op_wr <= 1'b1;
      code <= c;
      src <= s;
      dst <= d;
      len <= l;
      @(posedge clk);
      op_wr <= 1'b0;
      #1;
      chk({63'h0, busy}, 64'h1);
      k = 0;
      do begin
        @(posedge clk);
        #1;
        k = k + 1;
      end while (done !== 1'b1 && k < 2000);
      chk({63'h0, done}, 64'h1);
      chk({63'h0, busy}, 64'h0);
    end
  endtask
  task dig;
    begin
      chk(d0, ABC[255:192]);
      chk(d1, ABC[191:128]);
      chk(d2, ABC[127:64]);
      chk(d3, ABC[63:0]);
    end
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      complete_run;
    end
  end
  initial begin
    for (i = 0; i < 256; i = i + 1)
      mem.m[i] = {8{i[7:0]}};
    mem.m[64] = 64'h6162_6300_0000_0000;
    mem.m[65] = 64'h6100_0000_0000_0000;
    mem.m[66] = 64'h6263_0000_0000_0000;
    mem.m[96] = PH;
    mem.m[97] = PL;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    // unaligned base and length; destination set but unused
    run(4'h2, 35'h43, 35'h100, 35'h17);
    chk(mem.m[8], 64'h0);
    chk(mem.m[9], 64'h0);
    chk(mem.m[7], {8{8'h07}});
    chk(mem.m[10], {8{8'h0a}});
    chk(mem.m[32], {8{8'h20}});
    run(4'h2, 35'h58, 35'h0, 35'h10);
    chk(mem.m[12], 64'h0);
    chk(mem.m[13], {8{8'h0d}});
    run(4'h3, 35'h200, 35'h0, 35'h3);
    dig;
    run(4'h4, 35'h0, 35'h0, 35'h0);
    run(4'h5, 35'h208, 35'h0, 35'h1);
    run(4'h5, 35'h210, 35'h0, 35'h2);
    run(4'h6, 35'h0, 35'h0, 35'h0);
    dig;
    @(posedge clk);
    slow <= 1'b1;
    run(4'h7, 35'h0, 35'h0, 35'h0);
    @(posedge clk);
    // key ports change after expansion; the kept schedule must still serve
    key <= ~key;
    run(4'h8, 35'h300, 35'h380, 35'h10);
    chk(mem.m[112], CH);
    chk(mem.m[113], CL);
    run(4'hc, 35'h380, 35'h400, 35'h10);
    chk(mem.m[128], PH);
    chk(mem.m[129], PL);
    run(4'h9, 35'h300, 35'h500, 35'h10);
    run(4'ha, 35'h300, 35'h510, 35'h10);
    run(4'hb, 35'h300, 35'h520, 35'h10);
    chk(mem.m[160], CH);
    checks_done = checks_done + 1;
    if (mem.m[162] === CH) begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected at %0t: middle chunk not chained", $time);
    end
    run(4'hd, 35'h500, 35'h600, 35'h10);
    run(4'he, 35'h510, 35'h610, 35'h10);
    run(4'hf, 35'h520, 35'h620, 35'h10);
    for (i = 192; i < 198; i = i + 2) begin
      chk(mem.m[i], PH);
      chk(mem.m[i + 1], PL);
    end
    run(4'h1, 35'h200, 35'h700, 35'h8);
    chk(mem.m[224], 64'h6162_6300_0000_0000);
    // reset while idle after the move, then end a digest from the reset state
    @(posedge clk);
    rst_b <= 1'b0;
    @(posedge clk);
    chk({63'h0, busy}, 64'h0);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    run(4'h6, 35'h0, 35'h0, 35'h0);
    chk(d0, 64'he3b0_c442_98fc_1c14);
    chk(d3, 64'ha495_991b_7852_b855);
    run(4'h0, 35'h0, 35'h0, 35'h0);
    complete_run;
  end
endmodule
bind dhce_engine dhce_engine_chk #(.AW(AW)) u_chk (
  .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_op_wr(i_op_wr),
  .i_op_code(i_op_code), .o_task_state(o_task_state), .o_done(o_done),
  .o_mem_req(o_mem_req), .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr),
  .o_mem_wdata(o_mem_wdata), .i_mem_ack(i_mem_ack));
